/* shared/smdc_pkg.sv */
// package for the secure memory decode control block
package smdc_pkg;
    // timing of one expanded bus cycle, in core clocks
    localparam int unsigned CLK_PERIOD_NS    = 100;
    localparam int unsigned ALE_HIGH_NS      = 200;
    localparam int unsigned ALE_HIGH_CYC     = (ALE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STROBE_NS        = 600;
    localparam int unsigned STROBE_CYC       = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  ALE_HIGH_CNT     = 4'(ALE_HIGH_CYC - 1);
    localparam logic [3:0]  STROBE_CNT       = 4'(STROBE_CYC - 1);
    localparam logic [3:0]  CNT_RST          = 4'h0;
    // self-destruct deglitch: accept after this many stable cycles
    localparam int unsigned SDI_ACCEPT_NS    = 10000;
    localparam int unsigned SDI_ACCEPT_CYC   = (SDI_ACCEPT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  SDI_ACCEPT_CNT   = 8'(SDI_ACCEPT_CYC - 1);
    localparam logic [7:0]  SDI_RST          = 8'h00;
    // memory supply removal pulse length after a destruct
    localparam int unsigned VCCO_OFF_NS      = 10000;
    localparam int unsigned VCCO_OFF_CYC     = VCCO_OFF_NS / CLK_PERIOD_NS;
    localparam logic [7:0]  VCCO_OFF_CNT     = 8'(VCCO_OFF_CYC - 1);
    // memory map
    localparam logic [15:0] RTC_BASE         = 16'h0000;
    localparam logic [15:0] RTC_LIMIT        = 16'h00FF;
    localparam logic [63:0] KEY_RST          = 64'h0;
    localparam logic [7:0]  PORT_RST         = 8'hFF;
    localparam logic [15:0] ADDR_RST         = 16'h0000;
    localparam logic [2:0]  SYNC_RST         = 3'b000;
    localparam logic [2:0]  SYNC_RST_HI      = 3'b111;

    typedef enum logic [4:0] {
        SMDC_IDLE  = 5'b00001,
        SMDC_ADDR  = 5'b00010,
        SMDC_HOLD  = 5'b00100,
        SMDC_STRB  = 5'b01000,
        SMDC_DONE  = 5'b10000
    } smdc_state_t;

    // one data access from the core
    typedef struct packed {
        logic        req;
        logic        wr;
        logic        code;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } smdc_acc_t;

    // routing of one access
    typedef struct packed {
        logic nvram;
        logic rtc;
        logic expb;
        logic wprot;
        logic fault;
    } smdc_route_t;
endpackage : smdc_pkg

/* hdl/smdc_top.sv */
// memory decode, expanded bus sequencer and security pins
`timescale 1ns/1ps
module smdc_top
    import smdc_pkg::*;
#(
    parameter bit BIG_VARIANT = 1'b0
)(
    input  wire logic        i_core_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_reset_pin,
    input  wire logic        i_loader_entry_n,
    input  wire logic        i_self_destruct_in,
    input  wire logic        i_ext_irq0_n,
    input  wire logic        i_ext_irq1_n,
    input  wire logic        i_partition_mode_select,
    input  wire logic        i_rtc_space_select,
    input  wire logic [15:0] i_partition_addr,
    input  wire smdc_acc_t   i_acc,
    input  wire logic        i_load_valid,
    input  wire logic [7:0]  i_load_byte,
    input  wire logic [63:0] i_rng_key,
    input  wire logic [7:0]  i_gpio0_out,
    input  wire logic [7:0]  i_gpio2_out,
    input  wire logic [7:0]  i_low_addr_data_port_in,
    output logic [7:0]       o_low_addr_data_port_out,
    output logic [7:0]       o_low_addr_data_port_oe,
    output logic [7:0]       o_high_addr_port,
    output logic             o_ale,
    output logic             o_wr_n,
    output logic             o_rd_n,
    output logic             o_acc_done,
    output logic [7:0]       o_rdata,
    output smdc_route_t      o_route,
    output logic             o_core_reset,
    output logic             o_loader_start,
    output logic             o_irq0,
    output logic             o_irq1,
    output logic             o_erase,
    output logic             o_memory_supply_out,
    output logic             o_sram_we,
    output logic [7:0]       o_sram_wdata
);
    // pin synchronisers: three stages, change taken when stages 2 and 3 agree
    logic [2:0] rst_s_q, ldr_s_q, sdi_s_q, i0_s_q, i1_s_q;
    logic       rst_f_q, ldr_f_q, sdi_f_q, i0_f_q, i1_f_q;
    logic [2:0] rst_s_d, ldr_s_d, sdi_s_d, i0_s_d, i1_s_d;
    logic       rst_f_d, ldr_f_d, sdi_f_d, i0_f_d, i1_f_d;

    always_comb
    begin
        rst_s_d = {rst_s_q[1:0], i_reset_pin};
        ldr_s_d = {ldr_s_q[1:0], i_loader_entry_n};
        sdi_s_d = {sdi_s_q[1:0], i_self_destruct_in};
        i0_s_d  = {i0_s_q[1:0], i_ext_irq0_n};
        i1_s_d  = {i1_s_q[1:0], i_ext_irq1_n};
        rst_f_d = (rst_s_q[1] == rst_s_q[2]) ? rst_s_q[2] : rst_f_q;
        ldr_f_d = (ldr_s_q[1] == ldr_s_q[2]) ? ldr_s_q[2] : ldr_f_q;
        sdi_f_d = (sdi_s_q[1] == sdi_s_q[2]) ? sdi_s_q[2] : sdi_f_q;
        i0_f_d  = (i0_s_q[1] == i0_s_q[2]) ? i0_s_q[2] : i0_f_q;
        i1_f_d  = (i1_s_q[1] == i1_s_q[2]) ? i1_s_q[2] : i1_f_q;
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_s_q <= SYNC_RST;
            ldr_s_q <= SYNC_RST_HI;
            sdi_s_q <= SYNC_RST;
            i0_s_q  <= SYNC_RST_HI;
            i1_s_q  <= SYNC_RST_HI;
            rst_f_q <= 1'b0;
            ldr_f_q <= 1'b1;
            sdi_f_q <= 1'b0;
            i0_f_q  <= 1'b1;
            i1_f_q  <= 1'b1;
        end
        else
        begin
            rst_s_q <= rst_s_d;
            ldr_s_q <= ldr_s_d;
            sdi_s_q <= sdi_s_d;
            i0_s_q  <= i0_s_d;
            i1_s_q  <= i1_s_d;
            rst_f_q <= rst_f_d;
            ldr_f_q <= ldr_f_d;
            sdi_f_q <= sdi_f_d;
            i0_f_q  <= i0_f_d;
            i1_f_q  <= i1_f_d;
        end
    end

    assign o_core_reset = rst_f_q;
    assign o_irq0       = ~i0_f_q;
    assign o_irq1       = ~i1_f_q;

    // loader entry: falling edge, or level low caught once after power-up
    logic boot_seen_q, boot_seen_d, ldr_start_q, ldr_start_d, ldr_prev_q, ldr_prev_d;
    logic [2:0] ldr_fill_q, ldr_fill_d;
    always_comb
    begin
        boot_seen_d = boot_seen_q;
        ldr_prev_d  = ldr_f_q;
        ldr_start_d = 1'b0;
        ldr_fill_d  = {ldr_fill_q[1:0], 1'b1};
        // stages hold reset values until three edges pass; judging earlier misses a low pin
        if (!boot_seen_q && ldr_fill_q[2] && ldr_s_q[1] == ldr_s_q[2])
        begin
            boot_seen_d = 1'b1;
            ldr_prev_d  = ldr_s_q[2];
            ldr_start_d = ~ldr_s_q[2];
        end
        else if (boot_seen_q && ldr_prev_q && !ldr_f_q)
            ldr_start_d = 1'b1;
    end

    // self-destruct deglitch, then key erase and a supply drop pulse
    logic [7:0]  sdi_cnt_q, sdi_cnt_d, off_cnt_q, off_cnt_d;
    logic        erase_q, erase_d, vcco_q, vcco_d;
    logic [63:0] key_q, key_d;
    always_comb
    begin
        sdi_cnt_d = sdi_f_q ? sdi_cnt_q : SDI_RST;
        erase_d   = 1'b0;
        off_cnt_d = off_cnt_q;
        vcco_d    = vcco_q;
        key_d     = key_q;
        if (sdi_f_q && sdi_cnt_q != SDI_ACCEPT_CNT)
            sdi_cnt_d = sdi_cnt_q + 8'h01;
        else if (sdi_f_q && sdi_cnt_q == SDI_ACCEPT_CNT && vcco_q && off_cnt_q == SDI_RST)
        begin
            erase_d   = 1'b1;
            key_d     = KEY_RST;
            vcco_d    = 1'b0;
            off_cnt_d = VCCO_OFF_CNT;
        end
        if (!vcco_q)
        begin
            if (off_cnt_q == SDI_RST)
                vcco_d = 1'b1;
            else
                off_cnt_d = off_cnt_q - 8'h01;
        end
        // a new key is drawn from the random source on each loader entry, except in a cycle that also erases
        if (ldr_start_q && !erase_d)
            key_d = i_rng_key;
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            boot_seen_q <= 1'b0;
            ldr_prev_q  <= 1'b1;
            ldr_start_q <= 1'b0;
            ldr_fill_q  <= SYNC_RST;
            sdi_cnt_q   <= SDI_RST;
            off_cnt_q   <= SDI_RST;
            erase_q     <= 1'b0;
            vcco_q      <= 1'b1;
            key_q       <= KEY_RST;
        end
        else
        begin
            boot_seen_q <= boot_seen_d;
            ldr_prev_q  <= ldr_prev_d;
            ldr_start_q <= ldr_start_d;
            ldr_fill_q  <= ldr_fill_d;
            sdi_cnt_q   <= sdi_cnt_d;
            off_cnt_q   <= off_cnt_d;
            erase_q     <= erase_d;
            vcco_q      <= vcco_d;
            key_q       <= key_d;
        end
    end

    assign o_loader_start      = ldr_start_q;
    assign o_erase             = erase_q;
    assign o_memory_supply_out = vcco_q;

    // loader bytes: byte-wide xor stream keyed by address; plaintext never stored
    logic       swe_q, swe_d;
    logic [7:0] swd_q, swd_d;
    always_comb
    begin
        swe_d = i_load_valid;
        swd_d = i_load_byte ^ key_q[8*i_acc.addr[2:0] +: 8] ^ i_acc.addr[7:0];
    end

    // decode: partitioned mode is forced off on the large variant
    logic        part_mode;
    smdc_route_t rt;
    assign part_mode = ~i_partition_mode_select & ~BIG_VARIANT;
    always_comb
    begin
        rt = '0;
        if (i_acc.req)
        begin
            if (i_rtc_space_select && !i_acc.code
                && i_acc.addr >= RTC_BASE && i_acc.addr <= RTC_LIMIT)
                rt.rtc = 1'b1;
            else if (!part_mode)
                rt.nvram = 1'b1;
            else if (i_acc.code)
                // code beyond the partition is refused, not fetched off board
                rt.fault = (i_acc.addr >= i_partition_addr);
            else if (i_acc.addr >= i_partition_addr)
                rt.expb = 1'b1;
            else
                rt.nvram = 1'b1;
            // in partitioned mode the program segment sits below the boundary
            if (rt.nvram && part_mode && !i_acc.code && i_acc.wr)
            begin
                rt.nvram = 1'b0;
                rt.wprot = 1'b1;
            end
            if (rt.fault)
                rt.nvram = 1'b0;
            if (i_acc.code && !rt.fault)
                rt.nvram = 1'b1;
        end
    end

    // expanded bus sequencer
    smdc_state_t st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0]  wdat_q, wdat_d, rdat_q, rdat_d;
    logic        wr_q, wr_d, done_q, done_d;
    smdc_route_t rt_q, rt_d;
    always_comb
    begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        wr_d   = wr_q;
        rdat_d = rdat_q;
        done_d = 1'b0;
        rt_d   = rt_q;
        case (st_q)
            SMDC_IDLE:
            begin
                if (i_acc.req && !rst_f_q)
                begin
                    rt_d = rt;
                    if (rt.expb)
                    begin
                        st_d   = SMDC_ADDR;
                        addr_d = i_acc.addr;
                        wdat_d = i_acc.wdata;
                        wr_d   = i_acc.wr;
                        cnt_d  = ALE_HIGH_CNT;
                    end
                    else
                        done_d = 1'b1;
                end
            end
            SMDC_ADDR:
            begin
                if (cnt_q == CNT_RST)
                    st_d = SMDC_HOLD;
                else
                    cnt_d = cnt_q - 4'h1;
            end
            SMDC_HOLD:
            begin
                st_d  = SMDC_STRB;
                cnt_d = STROBE_CNT;
            end
            SMDC_STRB:
            begin
                if (cnt_q == CNT_RST)
                begin
                    st_d   = SMDC_DONE;
                    rdat_d = wr_q ? rdat_q : i_low_addr_data_port_in;
                end
                else
                    cnt_d = cnt_q - 4'h1;
            end
            SMDC_DONE:
            begin
                st_d   = SMDC_IDLE;
                done_d = 1'b1;
            end
            default:
                st_d = SMDC_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_q   <= SMDC_IDLE;
            cnt_q  <= CNT_RST;
            addr_q <= ADDR_RST;
            wdat_q <= 8'h00;
            rdat_q <= 8'h00;
            wr_q   <= 1'b0;
            done_q <= 1'b0;
            rt_q   <= '0;
            swe_q  <= 1'b0;
            swd_q  <= 8'h00;
        end
        else
        begin
            st_q   <= rst_f_q ? SMDC_IDLE : st_d;
            cnt_q  <= cnt_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            wr_q   <= wr_d;
            done_q <= done_d;
            rt_q   <= rt_d;
            swe_q  <= swe_d;
            swd_q  <= swd_d;
        end
    end

    // pin drive: port 0 only pulls low as plain I/O, so its enable tracks zero bits
    always_comb
    begin
        o_ale = (st_q == SMDC_ADDR);
        o_wr_n = !(st_q == SMDC_STRB && wr_q);
        o_rd_n = !(st_q == SMDC_STRB && !wr_q);
        o_high_addr_port = (st_q == SMDC_IDLE) ? i_gpio2_out : addr_q[15:8];
        if (st_q == SMDC_ADDR || st_q == SMDC_HOLD)
        begin
            o_low_addr_data_port_out = addr_q[7:0];
            o_low_addr_data_port_oe  = PORT_RST;
        end
        // write data stays one clock past the strobe's rise so the far side closes on it
        else if ((st_q == SMDC_STRB || st_q == SMDC_DONE) && wr_q)
        begin
            o_low_addr_data_port_out = wdat_q;
            o_low_addr_data_port_oe  = PORT_RST;
        end
        else if (st_q == SMDC_IDLE)
        begin
            o_low_addr_data_port_out = 8'h00;
            o_low_addr_data_port_oe  = ~i_gpio0_out;
        end
        else
        begin
            o_low_addr_data_port_out = 8'h00;
            o_low_addr_data_port_oe  = 8'h00;
        end
    end

    assign o_acc_done   = done_q;
    assign o_rdata      = rdat_q;
    assign o_route      = rt_q;
    assign o_sram_we    = swe_q;
    assign o_sram_wdata = swd_q;
endmodule : smdc_top

/* sim/smdc_top_asserts.sv */
// bus sequencing and security pin assertions for smdc_top
`timescale 1ns/1ps
module smdc_top_asserts
    import smdc_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_reset_pin,
    input  wire logic        i_ext_irq0_n,
    input  wire logic        i_load_valid,
    input  wire smdc_acc_t   i_acc,
    input  wire logic [7:0]  o_low_addr_data_port_out,
    input  wire logic [7:0]  o_low_addr_data_port_oe,
    input  wire logic [7:0]  o_high_addr_port,
    input  wire logic        o_ale,
    input  wire logic        o_wr_n,
    input  wire logic        o_rd_n,
    input  wire smdc_route_t o_route,
    input  wire logic        o_core_reset,
    input  wire logic        o_irq0,
    input  wire logic        o_erase,
    input  wire logic        o_memory_supply_out,
    input  wire logic        o_sram_we
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_addr_phase;
        o_ale[*2] ##1 (!o_ale && o_rd_n && o_wr_n);
    endsequence
    sequence s_one_strobe;
        (!o_rd_n ^ !o_wr_n);
    endsequence
    a_cycle_order: assert property ($rose(o_ale) |-> s_addr_phase ##1 s_one_strobe)
        else $error("bus cycle order wrong");
    a_rd_width: assert property ($fell(o_rd_n) |-> !o_rd_n[*6] ##1 o_rd_n)
        else $error("read strobe width wrong");
    a_wr_width: assert property ($fell(o_wr_n) |-> !o_wr_n[*6] ##1 o_wr_n)
        else $error("write strobe width wrong");
    a_addr_out: assert property (o_ale |-> o_low_addr_data_port_out == i_acc.addr[7:0]
        && o_low_addr_data_port_oe == 8'hFF && o_high_addr_port == i_acc.addr[15:8])
        else $error("address not on ports during latch strobe");
    a_wr_data: assert property (!o_wr_n |-> o_low_addr_data_port_out == i_acc.wdata
        && o_low_addr_data_port_oe == 8'hFF)
        else $error("write data not driven");
    a_rd_release: assert property (!o_rd_n |-> o_low_addr_data_port_oe == 8'h00)
        else $error("port not released on read");
    a_no_code_bus: assert property ($fell(o_rd_n) |-> !i_acc.code)
        else $error("code fetched over expanded bus");
    a_wprot_quiet: assert property (o_route.wprot |-> o_wr_n && o_rd_n)
        else $error("protected write reached the bus");
    a_pin_reset: assert property (i_reset_pin[*6] |-> o_core_reset && o_rd_n && o_wr_n)
        else $error("reset pin not obeyed");
    a_irq0_low: assert property (!i_ext_irq0_n[*5] |-> o_irq0)
        else $error("low interrupt pin not seen");
    a_supply_off: assert property ($rose(o_erase) |-> ##[0:2] !o_memory_supply_out)
        else $error("supply not removed on destruct");
    a_load_write: assert property (i_load_valid |=> o_sram_we)
        else $error("loader byte not written");
endmodule : smdc_top_asserts

bind smdc_top smdc_top_asserts chk_u (.i_core_clk, .i_arst_n, .i_reset_pin, .i_ext_irq0_n,
    .i_load_valid, .i_acc, .o_low_addr_data_port_out, .o_low_addr_data_port_oe,
    .o_high_addr_port, .o_ale, .o_wr_n, .o_rd_n, .o_route, .o_core_reset, .o_irq0,
    .o_erase, .o_memory_supply_out, .o_sram_we);

/* sim/smdc_bus_model.sv */
// expanded bus partner: address latch captured on the falling edge of ALE and a byte memory
`timescale 1ns/1ps
module smdc_bus_model #(
    parameter int DLY_NS = 250
)(
    input  wire logic        i_ale,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic [7:0]  i_pin,
    input  wire logic [7:0]  i_hi,
    output logic [7:0]       o_drv,
    output logic             o_oe,
    output logic [15:0]      o_lat
);
    logic [7:0] mem [0:255];
    initial
    begin
        o_oe = 1'b0;
        o_drv = 8'h00;
        o_lat = 16'h0000;
    end
    always @(negedge i_ale) o_lat = {i_hi, i_pin};
    always @(posedge i_wr_n) mem[o_lat[7:0]] = i_pin;
    // slow answer: data comes late in the strobe, pull-ups hold the wire before
    always @(negedge i_rd_n)
    begin
        #DLY_NS;
        if (!i_rd_n)
        begin
            o_drv = mem[o_lat[7:0]];
            o_oe = 1'b1;
        end
    end
    always @(posedge i_rd_n) o_oe = 1'b0;
endmodule : smdc_bus_model

/* sim/tb_smdc_top.sv */
// self-checking bench for the memory decode control block
`timescale 1ns/1ps
module tb_smdc_top;
    import smdc_pkg::*;
    logic        clk, arst_n, rst_pin, ldr_n, self_destruct_in, irq0_n, irq1_n, pm, rtc, ld_v;
    logic        ale, wr_n, rd_n, done, core_rst, ldr_go, irq0, irq1, erase, vcco;
    logic        sram_we, p_oe;
    logic [15:0] part, lat;
    logic [7:0]  ld_b, p0_out, p0_oe, p2, rdata, sram_wd, p_drv, pin;
    smdc_acc_t   acc;
    smdc_route_t route;
    int          fail_count, total_checks, nwr, nrd, w0, r0;

    // port 0 needs pull-ups: an undriven bit reads high
    assign pin = p_oe ? p_drv : ((p0_oe & p0_out) | ~p0_oe);
    always @(negedge wr_n) nwr++;
    always @(negedge rd_n) nrd++;

    smdc_top #(.BIG_VARIANT(1'b0)) dut_u (.i_core_clk(clk), .i_arst_n(arst_n),
        .i_reset_pin(rst_pin), .i_loader_entry_n(ldr_n), .i_self_destruct_in(self_destruct_in),
        .i_ext_irq0_n(irq0_n), .i_ext_irq1_n(irq1_n), .i_partition_mode_select(pm),
        .i_rtc_space_select(rtc), .i_partition_addr(part), .i_acc(acc),
        .i_load_valid(ld_v), .i_load_byte(ld_b), .i_rng_key(64'hC3A596E1B4D2785A),
        .i_gpio0_out(8'hFF), .i_gpio2_out(8'h5A), .i_low_addr_data_port_in(pin),
        .o_low_addr_data_port_out(p0_out), .o_low_addr_data_port_oe(p0_oe),
        .o_high_addr_port(p2), .o_ale(ale), .o_wr_n(wr_n), .o_rd_n(rd_n),
        .o_acc_done(done), .o_rdata(rdata), .o_route(route), .o_core_reset(core_rst),
        .o_loader_start(ldr_go), .o_irq0(irq0), .o_irq1(irq1), .o_erase(erase),
        .o_memory_supply_out(vcco), .o_sram_we(sram_we), .o_sram_wdata(sram_wd));
    smdc_bus_model #(.DLY_NS(250)) bus_u (.i_ale(ale), .i_rd_n(rd_n), .i_wr_n(wr_n),
        .i_pin(pin), .i_hi(p2), .o_drv(p_drv), .o_oe(p_oe), .o_lat(lat));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e)
        begin
            $display("BAD %s expected %h seen %h", n, e, s);
            fail_count++;
        end
    endtask : chk

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic wait_v(input string n, ref logic s, input logic v, input int lim);
        for (int k = 0; k < lim && s !== v; k++) step(1);
        chk(n, 16'(v), 16'(s));
    endtask : wait_v

    task access(input logic wr, input logic code, input logic [15:0] a, input logic [7:0] d);
        acc = '{1'b1, wr, code, a, d};
        wait_v("done", done, 1'b1, 40);
        acc.req = 1'b0;
        step(1);
    endtask : access

    task t_exp;
        pm = 1'b0;
        rtc = 1'b0;
        part = 16'h4000;
        w0 = nwr;
        r0 = nrd;
        access(1'b1, 1'b0, 16'h8123, 8'hA5);
        chk("route", 16'h0004, {11'h000, route});
        chk("latched address", 16'h8123, lat);
        chk("write strobes", 16'h0001, 16'(nwr - w0));
        access(1'b0, 1'b0, 16'h8123, 8'h00);
        chk("read data", 16'h00A5, {8'h00, rdata});
        chk("read strobes", 16'h0001, 16'(nrd - r0));
        $display("t_exp finished");
    endtask : t_exp

    task t_prot;
        w0 = nwr;
        access(1'b1, 1'b0, 16'h1000, 8'h3C);
        chk("route", 16'h0002, {11'h000, route});
        chk("write strobes", 16'h0000, 16'(nwr - w0));
        part = 16'h0800;
        access(1'b1, 1'b0, 16'h1000, 8'h3C);
        chk("route", 16'h0004, {11'h000, route});
        chk("write strobes", 16'h0001, 16'(nwr - w0));
        $display("t_prot finished");
    endtask : t_prot

    task t_map;
        r0 = nrd;
        access(1'b0, 1'b1, 16'h9000, 8'h00);
        chk("route", 16'h0001, {11'h000, route});
        rtc = 1'b1;
        access(1'b0, 1'b0, 16'h0010, 8'h00);
        chk("route", 16'h0008, {11'h000, route});
        rtc = 1'b0;
        pm = 1'b1;
        access(1'b0, 1'b0, 16'h9000, 8'h00);
        chk("route", 16'h0010, {11'h000, route});
        chk("read strobes", 16'h0000, 16'(nrd - r0));
        $display("t_map finished");
    endtask : t_map

    task t_pins;
        rst_pin = 1'b1;
        wait_v("core reset", core_rst, 1'b1, 8);
        rst_pin = 1'b0;
        wait_v("core reset", core_rst, 1'b0, 8);
        irq0_n = 1'b0;
        irq1_n = 1'b0;
        step(6);
        chk("irqs", 16'h0003, {14'h0, irq0, irq1});
        irq0_n = 1'b1;
        irq1_n = 1'b1;
        // one clean falling edge, as a debounced source gives
        ldr_n = 1'b0;
        wait_v("loader start", ldr_go, 1'b1, 10);
        ldr_n = 1'b1;
        step(3);
        acc.addr = 16'h0003;
        ld_b = 8'h5A;
        ld_v = 1'b1;
        step(1);
        ld_v = 1'b0;
        wait_v("sram write", sram_we, 1'b1, 2);
        chk("ciphered", 16'h0001, 16'(sram_wd !== 8'h5A));
        self_destruct_in = 1'b1;
        wait_v("erase", erase, 1'b1, 150);
        wait_v("supply off", vcco, 1'b0, 3);
        self_destruct_in = 1'b0;
        wait_v("supply back", vcco, 1'b1, 120);
        arst_n = 1'b0;
        ldr_n = 1'b0;
        step(3);
        arst_n = 1'b1;
        wait_v("boot loader", ldr_go, 1'b1, 10);
        ldr_n = 1'b1;
        step(1);
        chk("single loader start", 16'h0000, {15'h0000, ldr_go});
        $display("t_pins finished");
    endtask : t_pins

    task conclude;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    initial
    begin
        #1_000_000;
        fail_count++;
        conclude();
    end

    initial
    begin
        {arst_n, rst_pin, self_destruct_in, ld_v, pm, rtc} = 6'b000000;
        {ldr_n, irq0_n, irq1_n} = 3'b111;
        part = 16'h4000;
        ld_b = 8'h00;
        acc = '0;
        step(20);
        arst_n = 1'b1;
        step(4);
        t_exp();
        t_prot();
        t_map();
        t_pins();
        conclude();
    end
endmodule : tb_smdc_top
